//--- common/scx_defines.vh
// constants for the long subroutine-call execution block
// assumes 16-bit instruction words and a 21-bit byte program counter
`ifndef SCX_DEFINES_VH
`define SCX_DEFINES_VH
`define SCX_OP1_HI 15
`define SCX_OP1_LO 9
`define SCX_OP1_VAL 7'h76
`define SCX_SAVE_BIT 8
`define SCX_K_LO_HI 7
`define SCX_OP2_HI 15
`define SCX_OP2_LO 12
`define SCX_OP2_VAL 4'hf
`define SCX_K_HI_HI 11
`define SCX_PC_W 21
`define SCX_RET_OFS 21'h000004
`define SCX_ZERO_PC 21'h000000
`define SCX_ZERO_BYTE 8'h00
`define SCX_Q1 2'h0
`define SCX_Q2 2'h1
`define SCX_Q3 2'h2
`define SCX_Q4 2'h3
`endif

//--- rtl/scx_call_exec.v
// execution of the two-word long subroutine call
// assumes the fetch unit presents the current word for a whole instruction cycle
`timescale 1ns/1ps
`include "scx_defines.vh"
// Functional notes
// - call is two words: 1110110s k7..0, then 1111 k19..8
// - 20-bit word target reaches the whole 2-Mbyte space
// - push program counter plus 4 before the counter changes
// - save flag set copies working, flags, bank-select into shadows
// - save flag clear leaves all shadows unchanged
// - target loads counter bits 20..1, bit 0 forced zero
// - two cycles: decode, read, push, read, write; second cycle idle
module scx_call_exec (
  input wire mclk,
  input wire rst,
  input wire clkEn,
  input wire [15:0] instrWord,
  input wire [15:0] nextWord,
  input wire [20:0] programCounter,
  input wire [7:0] workingReg,
  input wire [7:0] flagsReg,
  input wire [7:0] bankSelectRegister,
  output wire [1:0] phase,
  output reg stackPush_q,
  output reg [20:0] returnAddr_q,
  output reg pcLoad_q,
  output reg [20:0] pcTarget_q,
  output reg [7:0] workingShadow_q,
  output reg [7:0] flagsShadow_q,
  output reg [7:0] bankSelectShadow_q,
  output reg callBusy_q,
  output reg badSecondWord_q
);
  // call sequencing: one state per instruction cycle of the call
  localparam [1:0] CS_IDLE = 2'b00;
  localparam [1:0] CS_FIRST = 2'b01;
  localparam [1:0] CS_SECOND = 2'b10;

  reg [1:0] callState_q;
  reg [1:0] callState_d;
  reg save_q;
  reg save_d;
  reg [7:0] kLow_q;
  reg [7:0] kLow_d;
  wire firstOk;
  wire secondOk;
  wire phaseQ1;
  wire phaseQ2;
  wire phaseQ3;
  wire phaseQ4;
  wire inIdle;
  wire inFirst;
  wire takeCall;
  wire pushNow;
  wire loadNow;
  wire copyNow;
  wire [20:0] returnAddr_d;
  wire [20:0] pcTarget_d;

  // opcode match on the first word of the pair
  function isFirstWord;
    input [15:0] word;
    begin
      isFirstWord = word[`SCX_OP1_HI:`SCX_OP1_LO] == `SCX_OP1_VAL;
    end
  endfunction

  // prefix match on the second word
  function isSecondWord;
    input [15:0] word;
    begin
      isSecondWord = word[`SCX_OP2_HI:`SCX_OP2_LO] == `SCX_OP2_VAL;
    end
  endfunction

  // word target to byte address, so the result is always even
  function [20:0] byteTarget;
    input [11:0] kHigh;
    input [7:0] kLowPart;
    begin
      byteTarget = {kHigh, kLowPart, 1'b0};
    end
  endfunction

  // address of the instruction after both call words
  function [20:0] returnOf;
    input [20:0] callAddr;
    begin
      returnOf = callAddr + `SCX_RET_OFS;
    end
  endfunction

  scx_qphase uPhase (
    .mclk(mclk),
    .rst(rst),
    .clkEn(clkEn),
    .phase_q(phase)
  );

  assign phaseQ1 = phase == `SCX_Q1;
  assign phaseQ2 = phase == `SCX_Q2;
  assign phaseQ3 = phase == `SCX_Q3;
  assign phaseQ4 = phase == `SCX_Q4;

  assign firstOk = isFirstWord(instrWord);
  assign secondOk = isSecondWord(nextWord);
  assign inIdle = callState_q == CS_IDLE;
  assign inFirst = callState_q == CS_FIRST;

  // a call word seen in Q1 of the dead second cycle is not taken
  assign takeCall = inIdle && phaseQ1 && firstOk;
  assign pushNow = inFirst && phaseQ2;
  assign loadNow = inFirst && phaseQ3;
  assign copyNow = pushNow && save_q;

  assign returnAddr_d = returnOf(programCounter);
  assign pcTarget_d = byteTarget(nextWord[`SCX_K_HI_HI:0], kLow_q);

  always @* begin
    callState_d = callState_q;
    case (callState_q)
      CS_IDLE: begin
        if (takeCall) begin
          callState_d = CS_FIRST;
        end
      end
      CS_FIRST: begin
        if (phaseQ4) begin
          callState_d = CS_SECOND;
        end
      end
      CS_SECOND: begin
        if (phaseQ4) begin
          callState_d = CS_IDLE;
        end
      end
      default: begin
        callState_d = CS_IDLE;
      end
    endcase
  end

  always @* begin
    save_d = save_q;
    kLow_d = kLow_q;
    if (takeCall) begin
      save_d = instrWord[`SCX_SAVE_BIT];
    end
    if (pushNow) begin
      kLow_d = instrWord[`SCX_K_LO_HI:0];
    end
  end

  // busy covers the whole second instruction cycle, Q1 to Q4
  always @(posedge mclk) begin
    if (rst) begin
      callState_q <= CS_IDLE;
      callBusy_q <= 1'b0;
    end else if (clkEn) begin
      callState_q <= callState_d;
      callBusy_q <= callState_d == CS_SECOND;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      save_q <= 1'b0;
      kLow_q <= `SCX_ZERO_BYTE;
    end else if (clkEn) begin
      save_q <= save_d;
      kLow_q <= kLow_d;
    end
  end

  // push goes out a phase ahead of the load, so the stack sees the old counter
  always @(posedge mclk) begin
    if (rst) begin
      stackPush_q <= 1'b0;
      returnAddr_q <= `SCX_ZERO_PC;
    end else if (clkEn) begin
      stackPush_q <= pushNow;
      if (pushNow) begin
        returnAddr_q <= returnAddr_d;
      end
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      pcLoad_q <= 1'b0;
      pcTarget_q <= `SCX_ZERO_PC;
    end else if (clkEn) begin
      pcLoad_q <= loadNow;
      if (loadNow) begin
        pcTarget_q <= pcTarget_d;
      end
    end
  end

  // diagnostic only: the target is still loaded from a bad second word
  always @(posedge mclk) begin
    if (rst) begin
      badSecondWord_q <= 1'b0;
    end else if (clkEn) begin
      if (loadNow) begin
        badSecondWord_q <= !secondOk;
      end else if (takeCall) begin
        badSecondWord_q <= 1'b0;
      end
    end
  end

  // shadows are written only here; the live flags are never written back
  always @(posedge mclk) begin
    if (rst) begin
      workingShadow_q <= `SCX_ZERO_BYTE;
    end else if (clkEn) begin
      if (copyNow) begin
        workingShadow_q <= workingReg;
      end
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      flagsShadow_q <= `SCX_ZERO_BYTE;
    end else if (clkEn) begin
      if (copyNow) begin
        flagsShadow_q <= flagsReg;
      end
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      bankSelectShadow_q <= `SCX_ZERO_BYTE;
    end else if (clkEn) begin
      if (copyNow) begin
        bankSelectShadow_q <= bankSelectRegister;
      end
    end
  end
endmodule // scx_call_exec

//--- rtl/scx_qphase.v
// four-phase instruction-cycle sequencer
// assumes one phase per enabled mclk edge
`timescale 1ns/1ps
`include "scx_defines.vh"
module scx_qphase (
  input wire mclk,
  input wire rst,
  input wire clkEn,
  output reg [1:0] phase_q
);
  always @(posedge mclk) begin
    if (rst) begin
      phase_q <= `SCX_Q1;
    end else if (clkEn) begin
      phase_q <= phase_q + 2'h1;
    end
  end
endmodule // scx_qphase

//--- verification/scx_call_exec_tb_top.sv
// call bench
// drives at falling edge
`timescale 1ns/1ps
`define CK(n,e,g) checks++; if ((g) !== (e)) begin fails++; $display("wrong value %s %h %h", n, e, g); end
module scx_call_exec_tb_top;
  reg mclk = 0, rst = 1, go = 0, s = 0, en = 1, sp = 0;
  reg [19:0] k = 20'h0;
  reg [20:0] pc = 21'h0;
  reg [7:0] w = 8'h0, f = 8'h0, b = 8'h0;
  wire [15:0] iw, nw;
  wire [20:0] ra, pt;
  wire [7:0] ws, fs, bs;
  wire [1:0] ph;
  wire bsy, bad;
  int fails = 0, checks = 0, cyc = 0;
  always #12.5 mclk = ~mclk;
  scx_fetch_model fm_u(.go(go), .s(s), .k(k), .spoil(sp), .instrWord(iw), .nextWord(nw));
  scx_call_exec dut_u(.mclk(mclk), .rst(rst), .clkEn(en), .instrWord(iw), .nextWord(nw), .programCounter(pc),
    .workingReg(w), .flagsReg(f), .bankSelectRegister(b), .phase(ph), .stackPush_q(), .returnAddr_q(ra),
    .pcLoad_q(), .pcTarget_q(pt), .workingShadow_q(ws), .flagsShadow_q(fs), .bankSelectShadow_q(bs),
    .callBusy_q(bsy), .badSecondWord_q(bad));
  task run(input reg sv, input reg [19:0] kv, input reg [20:0] pv);
    do @(negedge mclk); while (ph !== 2'h3 || bsy !== 1'b0);
    go = 1; s = sv; k = kv; pc = pv;
    repeat (4) @(negedge mclk);
    go = 0;
    repeat (5) @(negedge mclk);
  endtask
  task saveAll;
    w = 8'h5a; f = 8'h1f; b = 8'h0f;
    run(1'b1, 20'hfffff, 21'h1ffff8);
    `CK("ret", 21'h1ffffc, ra)
    `CK("tgt", 21'h1ffffe, pt)
    `CK("ws", 8'h5a, ws)
    `CK("fs", 8'h1f, fs)
    `CK("bs", 8'h0f, bs)
    `CK("bad", 1'b0, bad)
  endtask
  task keepShadows;
    w = 8'ha5; f = 8'h03; b = 8'h01;
    run(1'b0, 20'h00001, 21'h000100);
    `CK("ret", 21'h000104, ra)
    `CK("tgt", 21'h000002, pt)
    `CK("ws", 8'h5a, ws)
    `CK("fs", 8'h1f, fs)
    `CK("bs", 8'h0f, bs)
  endtask
  task badSecond;
    sp = 1;
    run(1'b0, 20'h00001, 21'h000100);
    `CK("bad", 1'b1, bad)
    sp = 0;
    run(1'b0, 20'h00001, 21'h000100);
    `CK("bad", 1'b0, bad)
    `CK("tgt", 21'h000002, pt)
  endtask
  // stall after the push, then offer a call word in the busy cycle's Q1
  task stallRefuse;
    do @(negedge mclk); while (ph !== 2'h3 || bsy !== 1'b0);
    w = 8'h11;
    f = 8'h22;
    b = 8'h33;
    go = 1;
    s = 1;
    k = 20'h12345;
    pc = 21'h0abc10;
    repeat (3) @(negedge mclk);
    en = 0;
    repeat (3) @(negedge mclk);
    `CK("ph", 2'h2, ph)
    `CK("ret", 21'h0abc14, ra)
    `CK("tgt", 21'h000002, pt)
    en = 1;
    repeat (2) @(negedge mclk);
    pc = 21'h000040;
    repeat (2) @(negedge mclk);
    `CK("bsy", 1'b1, bsy)
    go = 0;
    repeat (2) @(negedge mclk);
    `CK("bsy", 1'b0, bsy)
    `CK("ret", 21'h0abc14, ra)
    `CK("tgt", 21'h02468a, pt)
    `CK("ws", 8'h11, ws)
    `CK("fs", 8'h22, fs)
    `CK("bs", 8'h33, bs)
    `CK("bad", 1'b0, bad)
  endtask
  task conclude;
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 400) begin
      fails++;
      conclude;
    end
  end
  initial begin
    repeat (4) @(negedge mclk);
    rst = 0;
    saveAll;
    keepShadows;
    badSecond;
    stallRefuse;
    conclude;
  end
endmodule // scx_call_exec_tb_top

//--- verification/scx_call_props.sv
// call checker
// bound to scx_call_exec
`timescale 1ns/1ps
module scx_call_props(
  input wire mclk,
  input wire rst,
  input wire clkEn,
  input wire [15:0] instrWord,
  input wire [15:0] nextWord,
  input wire [20:0] programCounter,
  input wire [1:0] phase,
  input wire stackPush_q,
  input wire pcLoad_q,
  input wire [20:0] returnAddr_q,
  input wire [20:0] pcTarget_q,
  input wire [7:0] flagsShadow_q,
  input wire callBusy_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst || !clkEn);
  sequence callSeq; stackPush_q ##1 (pcLoad_q && !stackPush_q); endsequence
  wire q1Idle = phase == 2'h0 && !callBusy_q;
  take_a: assert property (q1Idle && instrWord[15:9] == 7'h76 |-> ##2 stackPush_q) else $error("take");
  skip_a: assert property (q1Idle && instrWord[15:9] != 7'h76 |-> ##2 !stackPush_q) else $error("skip");
  order_a: assert property (stackPush_q |-> callSeq) else $error("order");
  first_a: assert property (pcLoad_q |-> $past(stackPush_q)) else $error("first");
  ret_a: assert property ($rose(stackPush_q) |-> returnAddr_q == $past(programCounter) + 21'h4) else $error("ret");
  tgt_a: assert property ($rose(pcLoad_q) |-> pcTarget_q[20:9] == $past(nextWord[11:0]) && !pcTarget_q[0])
    else $error("tgt");
  idle_a: assert property ($rose(pcLoad_q) |-> ##1 callBusy_q [*4] ##1 !callBusy_q) else $error("idle");
  refuse_a: assert property (phase == 2'h0 && callBusy_q |-> ##2 !stackPush_q) else $error("refuse");
  shad_a: assert property ($changed(flagsShadow_q) |-> $rose(stackPush_q)) else $error("shad");
endmodule // scx_call_props
bind scx_call_exec scx_call_props p_u(
  .mclk(mclk),
  .rst(rst),
  .clkEn(clkEn),
  .instrWord(instrWord),
  .nextWord(nextWord),
  .programCounter(programCounter),
  .phase(phase),
  .stackPush_q(stackPush_q),
  .pcLoad_q(pcLoad_q),
  .returnAddr_q(returnAddr_q),
  .pcTarget_q(pcTarget_q),
  .flagsShadow_q(flagsShadow_q),
  .callBusy_q(callBusy_q)
);

//--- verification/scx_fetch_model.sv
// fetch model: the two call words
// bench holds go for one instruction cycle in run, on into the busy cycle in stallRefuse
`timescale 1ns/1ps
module scx_fetch_model(
  input wire go,
  input wire s,
  input wire [19:0] k,
  input wire spoil,
  output wire [15:0] instrWord,
  output wire [15:0] nextWord
);
  // idle words differ from the call so stale data is not reused
  assign instrWord = go ? {7'h76, s, k[7:0]} : 16'h0000;
  // spoil breaks the second-word prefix to exercise the diagnostic
  assign nextWord = (go && !spoil) ? {4'hf, k[19:8]} : {4'h0, ~k[19:8]};
endmodule // scx_fetch_model
